// ---- hw/fpi_pkg.sv ----
// Shared constants and types of the flash program interface.
package fpi_pkg;

  // Clock and operation timing.
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned PROG_TIME_NS = 16000;
  localparam int unsigned PROG_CYCLES  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [13:0] PROG_LAST    = 14'(PROG_CYCLES - 1);

  // Array geometry and CPU view.
  localparam int unsigned ARR_AW     = 14;
  localparam logic [1:0]  FLASH_SEL  = 2'h3;
  localparam logic [13:0] ARR_LAST   = 14'h3fff;
  localparam logic [13:0] PROT_ADDR  = 14'h3ffc;
  localparam logic [7:0]  PROT_CODE  = 8'h01;
  localparam logic [7:0]  ERASED     = 8'hff;

  // Register offsets in the CPU byte space (one bus word each).
  localparam logic [15:0] REG_FLASH_CONTROL_STATUS    = 16'h0079;
  localparam logic [15:0] REG_IRQ_STS = 16'h007a;
  localparam logic [15:0] REG_IRQ_CLR = 16'h007b;
  localparam logic [15:0] REG_IRQ_EN  = 16'h007c;

  // Control/status bit positions and reset values.
  localparam int unsigned FLASH_CONTROL_STATUS_IE   = 7;
  localparam int unsigned FLASH_CONTROL_STATUS_FLAG = 6;
  localparam int unsigned FLASH_CONTROL_STATUS_WE   = 5;
  localparam int unsigned FLASH_CONTROL_STATUS_RDY  = 4;
  localparam logic        FLASH_CONTROL_STATUS_RST  = 1'b0;
  localparam logic [2:0]  IRQ_RST   = 3'h0;

  // Event bits of the interrupt status register.
  localparam int unsigned NUM_EV = 3;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_REJ  = 1;
  localparam int unsigned EV_BLK  = 2;

  // Command cycles.
  localparam logic [11:0] CA_UNL1 = 12'h555;
  localparam logic [11:0] CA_UNL2 = 12'h2aa;
  localparam logic [7:0]  CD_UNL1 = 8'haa;
  localparam logic [7:0]  CD_UNL2 = 8'h55;
  localparam logic [7:0]  CD_PROG = 8'ha0;
  localparam logic [7:0]  CD_ERAS = 8'h80;
  localparam logic [7:0]  CD_CHIP = 8'h10;

  typedef enum logic [2:0] {
    CMD_IDLE = 3'b000, CMD_UNL1 = 3'b001, CMD_UNL2 = 3'b011,
    CMD_ARM  = 3'b010, CMD_ERA1 = 3'b110, CMD_ERA2 = 3'b111,
    CMD_ERA3 = 3'b101
  } fpi_cmd_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_PROG = 2'b01, SEQ_ERASE = 2'b11
  } fpi_seq_e;

endpackage

// ---- hw/fpi_mem.sv ----
// Flash array storage with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module fpi_mem (
  // Clock.
  input  wire logic                      i_core_clk,
  // Access port.
  input  wire logic                      i_we,
  input  wire logic [fpi_pkg::ARR_AW-1:0] i_addr,
  input  wire logic [7:0]                i_wdata,
  output logic      [7:0]                o_rdata_r
);
  import fpi_pkg::*;

  logic [7:0] mem [0:(1<<ARR_AW)-1];

  // The array is nonvolatile, so it has no reset.
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata_r <= mem[i_addr];
  end
endmodule // fpi_mem
`default_nettype wire

// ---- hw/fpi_seq.sv ----
// Self-timed program and chip-erase sequencer.
`timescale 1ns/10ps
`default_nettype none
module fpi_seq (
  // Clock and reset.
  input  wire logic                      i_core_clk,
  input  wire logic                      i_srst,
  // Start requests.
  input  wire logic                      i_prog,
  input  wire logic                      i_erase,
  input  wire logic [fpi_pkg::ARR_AW-1:0] i_addr,
  input  wire logic [7:0]                i_data,
  // Array write port and status.
  output logic                           o_we,
  output logic      [fpi_pkg::ARR_AW-1:0] o_waddr,
  output logic      [7:0]                o_wdata,
  output logic                           o_busy,
  output logic                           o_done
);
  import fpi_pkg::*;

  fpi_seq_e          st_r, st_nxt;
  logic [ARR_AW-1:0] cnt_r;
  logic [ARR_AW-1:0] addr_r;
  logic [7:0]        data_r;
  wire               prog_end  = (st_r == SEQ_PROG) && (cnt_r == PROG_LAST);
  wire               erase_end = (st_r == SEQ_ERASE) && (cnt_r == ARR_LAST);

  assign o_busy  = (st_r != SEQ_IDLE);
  assign o_we    = prog_end || (st_r == SEQ_ERASE);
  assign o_waddr = (st_r == SEQ_ERASE) ? cnt_r : addr_r;
  assign o_wdata = (st_r == SEQ_ERASE) ? ERASED : data_r;
  assign o_done  = prog_end || erase_end;

  // Once started, the sequence times itself with no help from the CPU.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SEQ_IDLE: begin
        if (i_prog) begin
          st_nxt = SEQ_PROG;
        end else if (i_erase) begin
          st_nxt = SEQ_ERASE;
        end
      end
      SEQ_PROG:  if (prog_end) st_nxt = SEQ_IDLE;
      SEQ_ERASE: if (erase_end) st_nxt = SEQ_IDLE;
      default:   st_nxt = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_r   <= SEQ_IDLE;
      cnt_r  <= '0;
      addr_r <= '0;
      data_r <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_nxt == st_r && o_busy) ? cnt_r + 14'h0001 : '0;
      if (!o_busy && i_prog) begin
        addr_r <= i_addr;
        data_r <= i_data;
      end
    end
  end
endmodule // fpi_seq
`default_nettype wire

// ---- hw/fpi_top.sv ----
// Flash program interface: bus slave, command decoder, status and guard.
// How it works
// - CPU reads and commands the array alike.
// - No array read overlaps a program/erase.
// - Array at C000-FFFF, programmer at 0000-3FFF.
// - Unprotected array is readable by programmer.
// - Code 01 at FFFC blocks programmer reads.
// - Program/erase run self-timed after acceptance.
// - Standard unlock command sequences are decoded.
// - Busy reads return polling and toggle bits.
// - Completion can raise a CPU interrupt.
// - I/O low, RAM above, program at top.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module fpi_top (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  // AHB-Lite slave.
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // External programmer read port.
  input  wire logic        i_prg_rd,
  input  wire logic [13:0] i_prg_addr,
  output logic      [7:0]  o_prg_data,
  output logic             o_prg_valid,
  output logic             o_prg_blocked,
  // Interrupt.
  output logic             o_irq
);
  import fpi_pkg::*;

  // Bus address phase.
  wire        ap       = i_hsel && i_htrans[1] && i_hready;
  wire [15:0] ap_addr  = i_haddr[17:2];
  wire        ap_map   = (i_haddr[31:18] == 14'h0000);
  wire        ap_flash = ap_map && (ap_addr[15:14] == FLASH_SEL);
  wire        bus_ard  = ap && !i_hwrite && ap_flash;

  logic        dp_valid_r;
  logic        dp_write_r;
  logic        dp_map_r;
  logic [15:0] dp_addr_r;
  logic        dp_busy_r;

  // Control and status state.
  fpi_cmd_e           cmd_r, cmd_nxt;
  logic               ie_r;
  logic               flag_r;
  logic               we_r;
  logic               tog_r;
  logic               poll_r;
  logic               prot_r;
  logic               boot_r;
  logic               load_r;
  logic [NUM_EV-1:0]  sts_r;
  logic [NUM_EV-1:0]  en_r;
  logic               prg_valid_r;
  logic               prg_blk_r;

  // Sequencer and memory links.
  logic              busy;
  logic              seq_we;
  logic              seq_done;
  logic [ARR_AW-1:0] seq_waddr;
  logic [7:0]        seq_wdata;
  logic [7:0]        mem_rdata;

  // Data phase decode.
  wire       dp_on    = dp_valid_r && dp_map_r;
  wire       dp_flash = dp_on && (dp_addr_r[15:14] == FLASH_SEL);
  wire       wr_arr   = dp_flash && dp_write_r;
  wire       rd_arr   = dp_flash && !dp_write_r;
  wire       stat_rd  = rd_arr && (dp_busy_r || busy);
  wire [7:0] wbyte    = i_hwdata[7:0];
  wire [11:0] ca      = dp_addr_r[11:0];
  wire       wr_flash_control_status  = dp_on && dp_write_r && (dp_addr_r == REG_FLASH_CONTROL_STATUS);
  wire       wr_clr   = dp_on && dp_write_r && (dp_addr_r == REG_IRQ_CLR);
  wire       wr_en    = dp_on && dp_write_r && (dp_addr_r == REG_IRQ_EN);

  // Commands are taken only while write enable is set and idle.
  wire cmd_ok  = wr_arr && we_r && !busy;
  wire reject  = wr_arr && !cmd_ok;
  wire unl1    = (ca == CA_UNL1) && (wbyte == CD_UNL1);
  wire unl2    = (ca == CA_UNL2) && (wbyte == CD_UNL2);
  wire at555   = (ca == CA_UNL1);
  wire do_prog = cmd_ok && (cmd_r == CMD_ARM);
  wire do_eras = cmd_ok && (cmd_r == CMD_ERA3) && at555 && (wbyte == CD_CHIP);

  // Programmer reads use the array only when the bus and sequencer do not.
  wire prg_take = i_prg_rd && !boot_r && !busy && !bus_ard;

  wire [ARR_AW-1:0] mem_addr = boot_r  ? PROT_ADDR :
                               seq_we  ? seq_waddr :
                               bus_ard ? ap_addr[ARR_AW-1:0] :
                               i_prg_addr;

  wire [7:0] flash_control_status_rd = {ie_r, flag_r, we_r, !busy, 4'h0};
  wire [7:0] stat_by = {poll_r, tog_r, 6'h00};
  wire [7:0] reg_rd  = (dp_addr_r == REG_FLASH_CONTROL_STATUS)    ? flash_control_status_rd :
                       (dp_addr_r == REG_IRQ_STS) ? {5'h00, sts_r} :
                       (dp_addr_r == REG_IRQ_EN)  ? {5'h00, en_r} :
                       8'h00;
  wire [7:0] rd_byte = (!dp_on || dp_write_r) ? 8'h00 :
                       stat_rd  ? stat_by :
                       dp_flash ? mem_rdata : reg_rd;
  wire [NUM_EV-1:0] ev;

  assign ev[EV_DONE] = seq_done;
  assign ev[EV_REJ]  = reject;
  assign ev[EV_BLK]  = prg_take && prot_r;

  assign o_hrdata      = {24'h000000, rd_byte};
  assign o_hreadyout   = 1'b1;
  assign o_hresp       = 1'b0;
  assign o_prg_valid   = prg_valid_r;
  assign o_prg_blocked = prg_blk_r;
  assign o_prg_data    = (prg_valid_r && !prg_blk_r) ? mem_rdata : 8'h00;
  assign o_irq         = (ie_r && flag_r) || |(sts_r & en_r);

  fpi_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_we       (seq_we),
    .i_addr     (mem_addr),
    .i_wdata    (seq_wdata),
    .o_rdata_r  (mem_rdata)
  );

  fpi_seq u_seq (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_prog     (do_prog),
    .i_erase    (do_eras),
    .i_addr     (dp_addr_r[ARR_AW-1:0]),
    .i_data     (wbyte),
    .o_we       (seq_we),
    .o_waddr    (seq_waddr),
    .o_wdata    (seq_wdata),
    .o_busy     (busy),
    .o_done     (seq_done)
  );

  // Unlock sequence decoder; any unexpected cycle falls back to idle.
  always_comb begin
    cmd_nxt = CMD_IDLE;
    case (cmd_r)
      CMD_IDLE: if (unl1) cmd_nxt = CMD_UNL1;
      CMD_UNL1: if (unl2) cmd_nxt = CMD_UNL2;
      CMD_UNL2: begin
        if (at555 && wbyte == CD_PROG) begin
          cmd_nxt = CMD_ARM;
        end else if (at555 && wbyte == CD_ERAS) begin
          cmd_nxt = CMD_ERA1;
        end
      end
      CMD_ERA1: if (unl1) cmd_nxt = CMD_ERA2;
      CMD_ERA2: if (unl2) cmd_nxt = CMD_ERA3;
      default:  cmd_nxt = CMD_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_map_r   <= 1'b0;
      dp_addr_r  <= 16'h0000;
      dp_busy_r  <= 1'b0;
    end else begin
      dp_valid_r <= ap;
      dp_write_r <= i_hwrite;
      dp_map_r   <= ap_map;
      dp_addr_r  <= ap_addr;
      dp_busy_r  <= busy;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cmd_r <= CMD_IDLE;
    end else if (reject) begin
      cmd_r <= CMD_IDLE;
    end else if (cmd_ok) begin
      cmd_r <= cmd_nxt;
    end
  end

  // The flag set by a finishing operation beats a clearing write.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ie_r   <= FLASH_CONTROL_STATUS_RST;
      flag_r <= FLASH_CONTROL_STATUS_RST;
      we_r   <= FLASH_CONTROL_STATUS_RST;
    end else begin
      if (wr_flash_control_status) begin
        ie_r <= wbyte[FLASH_CONTROL_STATUS_IE];
        we_r <= wbyte[FLASH_CONTROL_STATUS_WE];
      end
      if (seq_done) begin
        flag_r <= 1'b1;
      end else if (wr_flash_control_status && !wbyte[FLASH_CONTROL_STATUS_FLAG]) begin
        flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      tog_r  <= 1'b0;
      poll_r <= 1'b0;
    end else begin
      if (stat_rd) begin
        tog_r <= !tog_r;
      end
      if (do_prog) begin
        poll_r <= !wbyte[7];
      end else if (do_eras) begin
        poll_r <= 1'b0;
      end
    end
  end

  // Protection starts asserted and is loaded from the array after reset.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      boot_r <= 1'b1;
      load_r <= 1'b0;
      prot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      load_r <= boot_r;
      if (load_r) begin
        prot_r <= (mem_rdata == PROT_CODE);
      end else if (seq_we && seq_waddr == PROT_ADDR) begin
        prot_r <= (seq_wdata == PROT_CODE);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sts_r       <= IRQ_RST;
      en_r        <= IRQ_RST;
      prg_valid_r <= 1'b0;
      prg_blk_r   <= 1'b0;
    end else begin
      sts_r       <= (sts_r & ~(wr_clr ? wbyte[2:0] : 3'h0)) | ev;
      prg_valid_r <= prg_take;
      prg_blk_r   <= prg_take && prot_r;
      if (wr_en) begin
        en_r <= wbyte[2:0];
      end
    end
  end

  AST_PROG_BUSY: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    do_prog |=> busy [*8])
    else $error("Program did not hold busy.");

  AST_FLAG_SET: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    seq_done |=> flag_r && flash_control_status_rd[FLASH_CONTROL_STATUS_RDY])
    else $error("Completion flag not set.");

  AST_IRQ_OUT: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (seq_done && ie_r && !wr_flash_control_status) |=> o_irq)
    else $error("Enabled completion gave no interrupt.");

  AST_REJECT: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (wr_arr && !we_r) |=> sts_r[EV_REJ] && cmd_r == CMD_IDLE)
    else $error("Command taken without write enable.");

  AST_STATUS: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (rd_arr && busy) |-> o_hrdata[5:0] == 6'h00 && o_hrdata[6] == tog_r)
    else $error("Busy read did not return status.");

  AST_TOGGLE: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    stat_rd |=> tog_r != $past(tog_r))
    else $error("Toggle bit did not alternate.");

  AST_PROT: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (prg_take && prot_r) |=> o_prg_blocked && o_prg_data == 8'h00)
    else $error("Protected array was read out.");

  AST_OPEN: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (prg_take && !prot_r) |=> o_prg_valid && !o_prg_blocked)
    else $error("Unprotected read was refused.");

  AST_NO_OVL: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    busy |=> !o_prg_valid && !(rd_arr && !stat_rd))
    else $error("Array read during operation.");

  AST_MAP: assert property (
    @(posedge i_core_clk) disable iff (i_srst)
    (dp_on && !dp_write_r && dp_addr_r[15:8] == 8'h80) |-> o_hrdata == 0)
    else $error("Unmapped space returned data.");

endmodule // fpi_top
`default_nettype wire

// ---- test/fpi_cpu_model.sv ----
// CPU-side AHB-Lite master model issuing single word transfers.
`timescale 1ns/10ps
`default_nettype none
module fpi_cpu_model (
  // Clock.
  input  wire logic        i_core_clk,
  // AHB-Lite master side.
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [31:0] o_hwdata,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata
);
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
  end

  // Entered just after a rising edge; the CPU byte address becomes a word.
  // Array accesses during an operation only ever see status, never code.
  task automatic xfer(input logic wr, input logic [15:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    o_hsel <= 1'b1;
    o_htrans <= 2'h2;
    o_haddr <= {14'h0, addr, 2'h0};
    o_hwrite <= wr;
    o_hsize <= 3'h2;
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    o_hsel <= 1'b0;
    o_htrans <= 2'h0;
    o_hwdata <= {24'h0, wdata};
    do @(posedge i_core_clk); while (i_hready !== 1'b1);
    rdata = i_hrdata[7:0];
  endtask
endmodule // fpi_cpu_model
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking testbench of the flash program interface.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fpi_pkg::*;
  localparam logic [15:0]  ctrl_addr    = REG_FLASH_CONTROL_STATUS;
  localparam int           limit_cycles = 60000;
  // Chip-erase cycles, first cycle in the top bits: address then data.
  localparam logic [119:0] erase_seq    = {CA_UNL1, CD_UNL1,
    CA_UNL2, CD_UNL2, CA_UNL1, CD_ERAS, CA_UNL1, CD_UNL1,
    CA_UNL2, CD_UNL2, CA_UNL1, CD_CHIP};
  logic [19:0] ecyc;
  logic        clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        prg_rd;
  logic [13:0] prg_addr;
  logic [7:0]  prg_data;
  logic        prg_valid;
  logic        prg_blocked;
  logic        irq;
  logic [7:0]  r1;
  logic [7:0]  r2;
  logic        blk;
  int          bad_count;
  int          samples_checked;
  int          cyc;

  fpi_cpu_model cpu_u (.i_core_clk(clk), .o_hsel(hsel), .o_haddr(haddr),
    .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
    .o_hwdata(hwdata), .i_hready(hready), .i_hrdata(hrdata));

  fpi_top dut_u (.i_core_clk(clk), .i_srst(srst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_prg_rd(prg_rd), .i_prg_addr(prg_addr), .o_prg_data(prg_data),
    .o_prg_valid(prg_valid), .o_prg_blocked(prg_blocked), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done;
    $display("mismatches %0d, checks %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] v;
    cpu_u.xfer(1'b1, a, d, v);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    cpu_u.xfer(1'b0, a, 8'h00, v);
    chk(v, exp);
  endtask

  task automatic cmd(input logic [11:0] a, input logic [7:0] d);
    wr({4'hc, a}, d);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    cmd(CA_UNL1, CD_UNL1);
    cmd(CA_UNL2, CD_UNL2);
    cmd(CA_UNL1, CD_PROG);
    wr(a, d);
  endtask

  // Polls the ready bit; only the global timeout bounds the wait.
  task automatic wait_ready;
    logic [7:0] v;
    do cpu_u.xfer(1'b0, ctrl_addr, 8'h00, v); while (v[FLASH_CONTROL_STATUS_RDY] !== 1'b1);
  endtask

  // The last held cycle yields one extra answer, drained afterwards.
  task automatic prg_read(input logic [13:0] a, output logic [7:0] d,
                          output logic b);
    prg_rd <= 1'b1;
    prg_addr <= a;
    do @(posedge clk); while (prg_valid !== 1'b1);
    d = prg_data;
    b = prg_blocked;
    prg_rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == limit_cycles) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    srst = 1'b1;
    prg_rd = 1'b0;
    prg_addr = 14'h0;
    bad_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(ctrl_addr, 8'h10);
    rdchk(REG_IRQ_EN, 8'h00);
    wr(REG_IRQ_EN, 8'h07);
    cmd(CA_UNL1, CD_UNL1);
    rdchk(REG_IRQ_STS, 8'h02);
    @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    wr(REG_IRQ_CLR, 8'h07);
    wr(REG_IRQ_EN, 8'h00);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    rdchk(16'h0100, 8'h00);
    rdchk(16'h8000, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    wr(ctrl_addr, 8'h20);
    rdchk(ctrl_addr, 8'h30);
    for (int i = 0; i < 6; i++) begin
      ecyc = erase_seq[100-20*i +: 20];
      cmd(ecyc[19:8], ecyc[7:0]);
    end
    cpu_u.xfer(1'b0, 16'hc000, 8'h00, r1);
    cpu_u.xfer(1'b0, 16'hc000, 8'h00, r2);
    chk({r1[7], r1[5:0]}, 8'h00);
    chk({7'h0, r1[6] ^ r2[6]}, 8'h01);
    rdchk(ctrl_addr, 8'h20);
    wait_ready();
    rdchk(ctrl_addr, 8'h70);
    chk({7'h0, irq}, 8'h00);
    wr(ctrl_addr, 8'he0);
    @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    wr(ctrl_addr, 8'ha0);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    rdchk(16'hffff, ERASED);
    prog(16'hc123, 8'h5a);
    cpu_u.xfer(1'b0, 16'hc123, 8'h00, r1);
    chk({7'h0, r1[7]}, 8'h01);
    wait_ready();
    rdchk(16'hc123, 8'h5a);
    @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    prg_read(14'h0123, r1, blk);
    chk(r1, 8'h5a);
    chk({7'h0, blk}, 8'h00);
    prog(16'hfffc, PROT_CODE);
    cmd(CA_UNL1, CD_UNL1);
    wait_ready();
    prg_read(14'h0123, r1, blk);
    chk(r1, 8'h00);
    chk({7'h0, blk}, 8'h01);
    rdchk(16'hc123, 8'h5a);
    rdchk(REG_IRQ_STS, 8'h07);
    test_done();
  end
endmodule // tb
`default_nettype wire
